// *** hdl/exc_pkg.sv ***
// package: constants, types and register map for the exception sequencer
package exc_pkg;
  // ---------------------------------------------------------------
  // vector numbers
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_RESET    = 8'h00;
  localparam logic [7:0] VEC_ILLEGAL  = 8'h04;
  localparam logic [7:0] VEC_TRACE    = 8'h05;
  localparam logic [7:0] VEC_NMI      = 8'h07;
  localparam logic [7:0] VEC_TRAP0    = 8'h08;
  localparam logic [7:0] VEC_CPU_AERR = 8'h0c;
  localparam logic [7:0] VEC_DTC_AERR = 8'h0d;
  localparam logic [7:0] VEC_SLEEP    = 8'h12;
  localparam logic [7:0] VEC_EXT_IRQ0 = 8'h40;
  localparam int         EXT_IRQ_N    = 12;
  localparam logic [7:0] VEC_RSV_LO   = 8'h4c;
  localparam logic [7:0] VEC_RSV_HI   = 8'h4f;
  localparam logic [7:0] VEC_INT_LO   = 8'h50;
  localparam int         ENTRY_SHIFT  = 2;
  localparam int         ICM_TRACE    = 2;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_VBASE   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;
  localparam logic [7:0]  ADDR_LASTVEC = 8'h0c;
  localparam logic [7:0]  ADDR_HANDLER = 8'h10;
  localparam logic [7:0]  ADDR_ID      = 8'h14;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE     = 32'h0000_e5c1;
  // ctrl fields
  localparam int CTRL_TRACE   = 0;
  localparam int CTRL_ICM     = 1;
  localparam int CTRL_SOFTWARE_STANDBY_SELECT    = 2;
  localparam int CTRL_SLEEP_IRQ_ENABLE   = 3;
  localparam int CTRL_SP_INIT = 4;
  localparam int CTRL_EXR_I   = 5;
  localparam int CTRL_CCR_I   = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0060;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       boundary;
    logic       illegal;
    logic       rte_done;
    logic       ctrl_instr;
    logic       aerr_cpu;
    logic       aerr_dtc;
    logic       sleep;
    logic       trap;
    logic [1:0] trap_num;
  } core_req_t;

  typedef struct packed {
    logic       nmi;
    logic       irq;
    logic [7:0] vec;
  } irq_req_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_RESET, SRC_ILLEGAL, SRC_TRACE, SRC_AERR, SRC_IRQ, SRC_SLEEP, SRC_TRAP
  } src_t;
endpackage

// *** hdl/exception_priority_vectoring.sv ***
// exception arbitration, vector address forming and vector fetch
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// (RULE1) pending exceptions taken by priority: reset, illegal, trace, aerr, irq, sleep, trap
// (RULE2) held in reset while input low; reset handling starts at rise or watchdog; a watchdog pulse during a vector fetch is ignored here
// (RULE3) undefined instruction code raises illegal-instruction exception
// (RULE4) trace after each instruction when flag set, mode 2, not after return
// (RULE5) address error deferred until current instruction completes
// (RULE6) interrupts checked per boundary, not after control or load instrs, reset
// (RULE7) sleep exception only when standby select 0 and sleep enable 1
// (RULE8) trap raises exception; trap and sleep accepted any time in execution
// (RULE9) fixed vector numbers for reset, illegal, trace, nmi, traps, errors, sleep
// (RULE10) entry is four bytes at vector number times four, lower 16 bits
// (RULE11) external lines 0 to 11 map to vectors 64 to 75
// (RULE12) table address is vector base plus offset for most exceptions
// (RULE13) reset and cpu address error use the offset alone
// (RULE14) handler start address fetched from table, execution begins there
// (RULE15) reset input low halts everything at once; reset outranks all
// (RULE16) reset source holds input low 20 ms at power-on, 20 cycles running
// (RULE17) reset initialises state and leaves interrupt control mode at 0
// (RULE18) reset clears vector base and trace flag, sets both mask bits
// (RULE19) reset reads reset entry into program counter and starts there
// (RULE20) data transfer controller address error uses its own vector 13
// (RULE21) all interrupts blocked after reset until stack pointer initialised
// (RULE22) entry fetch reads one word before handler's first fetch
// (RULE23) one decision per boundary; only highest-priority exception dispatched
module exception_priority_vectoring (
  input  wire logic                aclk,          // system clock 125 MHz
  input  wire logic                aresetn,       // bus reset, active low
  input  wire logic                hw_reset_input,// reset pin level, low = reset
  input  wire logic                wdt_overflow,  // watchdog overflow pulse
  input  wire exc_pkg::core_req_t  core_req,      // pipeline requests
  input  wire exc_pkg::irq_req_t   irq_req,       // controller request
  input  wire logic [11:0]         external_irq_lines, // direct irq lines
  output logic                     core_halt,     // core held, level
  output logic                     dispatch,      // one-cycle dispatch pulse
  output logic [7:0]               dispatch_vec,  // vector dispatched
  output logic                     pc_load,       // load handler address pulse
  output logic [31:0]              pc_value,      // handler start address
  output logic                     irq_ack,       // irq accepted pulse
  output logic                     mem_req,       // vector fetch request
  output logic [31:0]              mem_addr,      // vector table address
  input  wire logic                mem_ack,       // fetch done
  input  wire logic [31:0]         mem_rdata,     // fetched entry
  input  wire logic [7:0]          s_axi_awaddr,  // axi4-lite
  input  wire logic                s_axi_awvalid, // axi4-lite
  output logic                     s_axi_awready, // axi4-lite
  input  wire logic [31:0]         s_axi_wdata,   // axi4-lite
  input  wire logic [3:0]          s_axi_wstrb,   // axi4-lite
  input  wire logic                s_axi_wvalid,  // axi4-lite
  output logic                     s_axi_wready,  // axi4-lite
  output logic [1:0]               s_axi_bresp,   // axi4-lite
  output logic                     s_axi_bvalid,  // axi4-lite
  input  wire logic                s_axi_bready,  // axi4-lite
  input  wire logic [7:0]          s_axi_araddr,  // axi4-lite
  input  wire logic                s_axi_arvalid, // axi4-lite
  output logic                     s_axi_arready, // axi4-lite
  output logic [31:0]              s_axi_rdata,   // axi4-lite
  output logic [1:0]               s_axi_rresp,   // axi4-lite
  output logic                     s_axi_rvalid,  // axi4-lite
  input  wire logic                s_axi_rready   // axi4-lite
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_FETCH} phase_t;
  phase_t      phase_r, phase_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] vector_base_r;
  logic        pin_q_r;
  logic        aerr_cpu_r, aerr_dtc_r, sleep_r, trap_r, illegal_r;
  logic [1:0]  trap_num_r;
  logic        after_reset_r;
  logic [7:0]  last_vec_r;
  logic [31:0] handler_r;
  logic        fetch_rst_r;

  function automatic logic [31:0] entry_off(input logic [7:0] v);
    entry_off = {22'h0, v, 2'b00};  // see (RULE10)
  endfunction

  wire logic reset_rise   = hw_reset_input & ~pin_q_r;  // see (RULE2)
  wire logic reset_start  = reset_rise | wdt_overflow;
  wire logic in_reset     = ~hw_reset_input;             // see (RULE15)
  wire logic boundary     = (phase_r == ST_RUN) & core_req.boundary;
  localparam int CTRL_TRACE_IDX = exc_pkg::CTRL_TRACE;
  wire logic trace_on     = ctrl_r[CTRL_TRACE_IDX] & ctrl_r[exc_pkg::CTRL_ICM];
  // icm bit set = mode 2, clear = mode 0
  wire logic trace_pend   = trace_on & ~core_req.rte_done;            // see (RULE4)
  wire logic irq_allowed  = ctrl_r[exc_pkg::CTRL_SP_INIT] & ~core_req.ctrl_instr
                            & ~after_reset_r;                         // see (RULE6)
  wire logic [11:0] ext_m = external_irq_lines;
  wire logic ext_any      = |ext_m;
  logic [3:0] ext_idx;
  always_comb begin
    ext_idx = 4'h0;
    for (int i = exc_pkg::EXT_IRQ_N - 1; i >= 0; i--) begin
      if (ext_m[i]) begin
        ext_idx = 4'(i);
      end
    end
  end
  wire logic irq_pend     = irq_allowed & (irq_req.nmi | irq_req.irq | ext_any); // see (RULE21)
  wire logic [7:0] irq_vec = irq_req.nmi ? exc_pkg::VEC_NMI :
                             irq_req.irq ? irq_req.vec :
                             exc_pkg::VEC_EXT_IRQ0 + {4'h0, ext_idx};       // see (RULE11)
  wire logic sleep_ok     = ~ctrl_r[exc_pkg::CTRL_SOFTWARE_STANDBY_SELECT] & ctrl_r[exc_pkg::CTRL_SLEEP_IRQ_ENABLE];
  wire logic aerr_pend    = aerr_cpu_r | aerr_dtc_r;

  // ---------------------------------------------------------------
  // priority selection
  // ---------------------------------------------------------------
  exc_pkg::src_t sel;
  always_comb begin
    if (illegal_r)       sel = exc_pkg::SRC_ILLEGAL;  // see (RULE1)
    else if (trace_pend) sel = exc_pkg::SRC_TRACE;
    else if (aerr_pend)  sel = exc_pkg::SRC_AERR;
    else if (irq_pend)   sel = exc_pkg::SRC_IRQ;
    else if (sleep_r)    sel = exc_pkg::SRC_SLEEP;
    else if (trap_r)     sel = exc_pkg::SRC_TRAP;
    else                 sel = exc_pkg::SRC_NONE;
  end

  logic [7:0] sel_vec;
  always_comb begin
    case (sel)
      exc_pkg::SRC_ILLEGAL: sel_vec = exc_pkg::VEC_ILLEGAL;   // see (RULE9)
      exc_pkg::SRC_TRACE:   sel_vec = exc_pkg::VEC_TRACE;
      exc_pkg::SRC_AERR:    sel_vec = aerr_cpu_r ? exc_pkg::VEC_CPU_AERR
                                                 : exc_pkg::VEC_DTC_AERR; // see (RULE20)
      exc_pkg::SRC_IRQ:     sel_vec = irq_vec;
      exc_pkg::SRC_SLEEP:   sel_vec = exc_pkg::VEC_SLEEP;
      exc_pkg::SRC_TRAP:    sel_vec = exc_pkg::VEC_TRAP0 + {6'h0, trap_num_r};
      default:              sel_vec = exc_pkg::VEC_RESET;
    endcase
  end
  // vector base ignored for reset and cpu address error
  wire logic use_base = !(sel == exc_pkg::SRC_AERR && aerr_cpu_r);    // see (RULE13)
  wire logic [31:0] tbl_addr = (use_base ? vector_base_r : 32'h0) + entry_off(sel_vec); // see (RULE12)
  wire logic take = boundary & (sel != exc_pkg::SRC_NONE);            // see (RULE23)

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      ST_RESET: if (reset_start) phase_nxt = ST_FETCH;
      ST_RUN:   if (take | wdt_overflow) phase_nxt = ST_FETCH;
      ST_FETCH: if (mem_ack) phase_nxt = ST_RUN;                      // see (RULE22)
      default:  phase_nxt = ST_RESET;
    endcase
    if (in_reset) phase_nxt = ST_RESET;                               // see (RULE15)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= ST_RESET;
      pin_q_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      pin_q_r <= hw_reset_input;
    end
  end

  // ---------------------------------------------------------------
  // pending request latches, defer address error to boundary
  // ---------------------------------------------------------------
  wire logic clr_all = in_reset | (phase_r == ST_RESET);
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_all) begin
      aerr_cpu_r <= 1'b0;
      aerr_dtc_r <= 1'b0;
      sleep_r    <= 1'b0;
      trap_r     <= 1'b0;
      trap_num_r <= 2'b00;
      illegal_r  <= 1'b0;
    end else begin
      aerr_cpu_r <= core_req.aerr_cpu | (aerr_cpu_r & ~(take & sel == exc_pkg::SRC_AERR)); // see (RULE5)
      aerr_dtc_r <= core_req.aerr_dtc | (aerr_dtc_r & ~(take & sel == exc_pkg::SRC_AERR & ~aerr_cpu_r));
      illegal_r  <= core_req.illegal | (illegal_r & ~(take & sel == exc_pkg::SRC_ILLEGAL)); // see (RULE3)
      sleep_r    <= (core_req.sleep & sleep_ok) | (sleep_r & ~(take & sel == exc_pkg::SRC_SLEEP)); // see (RULE7)
      trap_r     <= core_req.trap | (trap_r & ~(take & sel == exc_pkg::SRC_TRAP)); // see (RULE8)
      if (core_req.trap) trap_num_r <= core_req.trap_num;
    end
  end

  // ---------------------------------------------------------------
  // dispatch and vector fetch
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      dispatch      <= 1'b0;
      dispatch_vec  <= 8'h00;
      irq_ack       <= 1'b0;
      mem_req       <= 1'b0;
      mem_addr      <= 32'h0;
      pc_load       <= 1'b0;
      pc_value      <= 32'h0;
      last_vec_r    <= 8'h00;
      handler_r     <= 32'h0;
      fetch_rst_r   <= 1'b0;
      after_reset_r <= 1'b1;
    end else begin
      dispatch <= 1'b0;
      irq_ack  <= 1'b0;
      pc_load  <= 1'b0;
      if ((phase_r == ST_RESET && reset_start) || (phase_r == ST_RUN && wdt_overflow)) begin
        mem_req      <= 1'b1;
        mem_addr     <= entry_off(exc_pkg::VEC_RESET);   // see (RULE19)
        dispatch     <= 1'b1;
        dispatch_vec <= exc_pkg::VEC_RESET;
        last_vec_r   <= exc_pkg::VEC_RESET;
        fetch_rst_r  <= 1'b1;
      end else if (take) begin
        mem_req      <= 1'b1;
        mem_addr     <= tbl_addr;
        dispatch     <= 1'b1;
        dispatch_vec <= sel_vec;
        last_vec_r   <= sel_vec;
        irq_ack      <= (sel == exc_pkg::SRC_IRQ);
        fetch_rst_r  <= 1'b0;
      end else if (phase_r == ST_FETCH && mem_ack) begin
        mem_req       <= 1'b0;
        pc_load       <= 1'b1;                          // see (RULE14)
        pc_value      <= mem_rdata;
        handler_r     <= mem_rdata;
        after_reset_r <= fetch_rst_r;
      end else if (boundary) begin
        after_reset_r <= 1'b0;
      end
    end
  end
  assign core_halt = (phase_r != ST_RUN);                 // see (RULE15)

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic       aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  // watchdog reset reinitialises registers too, except mid-fetch where it is ignored
  wire logic wdt_rst = wdt_overflow & (phase_r != ST_FETCH);   // see (RULE17) (RULE18)
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire logic wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire logic wr_ok = (aw_addr_r == exc_pkg::ADDR_CTRL) | (aw_addr_r == exc_pkg::ADDR_VBASE);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset || wdt_rst) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= exc_pkg::RESP_OKAY;
      ctrl_r        <= exc_pkg::CTRL_RESET;               // see (RULE17) (RULE18)
      vector_base_r <= 32'h0;                             // see (RULE18)
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? exc_pkg::RESP_OKAY : exc_pkg::RESP_SLVERR;
        if (aw_addr_r == exc_pkg::ADDR_CTRL) ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h7f;
        if (aw_addr_r == exc_pkg::ADDR_VBASE) vector_base_r <= merge(vector_base_r, w_data_r, w_strb_r);
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (take & (sel == exc_pkg::SRC_TRACE | sel == exc_pkg::SRC_AERR)) begin
        ctrl_r[exc_pkg::CTRL_TRACE] <= 1'b0;
        ctrl_r[exc_pkg::CTRL_CCR_I] <= 1'b1;
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      exc_pkg::ADDR_CTRL:    rd_mux = ctrl_r;
      exc_pkg::ADDR_VBASE:   rd_mux = vector_base_r;
      exc_pkg::ADDR_STATUS:  rd_mux = {24'h0, aerr_dtc_r, aerr_cpu_r, illegal_r, sleep_r,
                                       trap_r, after_reset_r, 2'(phase_r)};
      exc_pkg::ADDR_LASTVEC: rd_mux = {24'h0, last_vec_r};
      exc_pkg::ADDR_HANDLER: rd_mux = handler_r;
      exc_pkg::ADDR_ID:      rd_mux = exc_pkg::ID_VALUE;
      default:               rd_mux = 32'h0;
    endcase
  end
  wire logic rd_ok = (s_axi_araddr <= exc_pkg::ADDR_ID) & (s_axi_araddr[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= exc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? exc_pkg::RESP_OKAY : exc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_reset_halts: assert property (@(posedge aclk) disable iff (!aresetn)
    !hw_reset_input |=> core_halt && !pc_load) else $error("reset did not halt"); // see (RULE15)
  chk_reset_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase_r == ST_RESET && reset_start && hw_reset_input) |=> mem_req && mem_addr == 32'h0)
    else $error("reset fetch address wrong"); // see (RULE19)
  chk_illegal_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && illegal_r) |=> dispatch_vec == 8'h04) else $error("illegal not first"); // see (RULE1)
  chk_cpu_aerr_base: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && sel == exc_pkg::SRC_AERR && aerr_cpu_r) |=> mem_addr == 32'h30)
    else $error("cpu address error used base"); // see (RULE13)
  chk_base_added: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && sel == exc_pkg::SRC_TRAP) |=> mem_addr == $past(vector_base_r) + 32'h20 + {28'h0, $past(trap_num_r), 2'b00})
    else $error("trap address wrong"); // see (RULE12)
  chk_sleep_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (take && sel == exc_pkg::SRC_SLEEP) |-> sleep_ok) else $error("sleep without enable"); // see (RULE7)
  chk_irq_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r[exc_pkg::CTRL_SP_INIT] |-> ##1 !irq_ack) else $error("irq before stack init"); // see (RULE21)
  chk_fetch_then_pc: assert property (@(posedge aclk) disable iff (!aresetn || !hw_reset_input)
    (phase_r == ST_FETCH && mem_ack) |=> pc_load && pc_value == $past(mem_rdata))
    else $error("handler not loaded"); // see (RULE14)
endmodule

// *** dv/vec_mem_model.sv ***
// memory bus model answering vector entry fetches
`timescale 1ns/100ps
module vec_mem_model #(
  parameter logic [31:0] KEY = 32'h5a5a_0f0f // folded into every entry word
) (
  input  wire logic        aclk,      // system clock
  input  wire logic        aresetn,   // sync reset, low
  input  wire logic        mem_req,   // fetch request, level
  input  wire logic [31:0] mem_addr,  // entry address
  output logic             mem_ack,   // one-cycle answer
  output logic [31:0]      mem_rdata  // entry word
);
  logic [2:0] wait_r;
  logic       slow_r;
  // ----------------------------------------------------------
  // alternate prompt and slow answers; data toggles when idle
  // ----------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r <= 3'h0;
      slow_r <= 1'b0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      slow_r <= ~slow_r;
      wait_r <= 3'h0;
    end else if (mem_req && wait_r >= (slow_r ? 3'h5 : 3'h0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr ^ KEY;
    end else begin
      wait_r <= mem_req ? wait_r + 3'h1 : 3'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// *** dv/exception_priority_vectoring_tb.sv ***
// self-checking bench for the exception sequencer
`timescale 1ns/100ps
module exception_priority_vectoring_tb;
  localparam logic [31:0] KEY = 32'h5a5a_0f0f;
  localparam logic [31:0] VB  = 32'h0001_0000;
  logic aclk, aresetn, hw_reset_input, wdt_overflow, mem_req, mem_ack, dispatch, pc_load;
  logic core_halt, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0]  dispatch_vec, awaddr, araddr;
  logic [31:0] pc_value, mem_addr, mem_rdata, wdata, rdata;
  logic [1:0]  rresp;
  logic [1:0]  bresp;
  logic        irq_ack;
  logic [11:0] ext;
  exc_pkg::core_req_t core_req, q, r;
  exc_pkg::irq_req_t  irq_req;
  int bad_count, n_checks;

  exception_priority_vectoring DUT (
    .aclk, .aresetn, .hw_reset_input, .wdt_overflow, .core_req, .irq_req,
    .external_irq_lines(ext), .core_halt, .dispatch, .dispatch_vec, .pc_load, .pc_value,
    .irq_ack(irq_ack), .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  vec_mem_model #(.KEY(KEY)) mem (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------------------------
  // handshakes are judged at the negedge before the taking edge
  // ----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    logic [1:0] e;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      e = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, e}, {30'h0, (a == exc_pkg::ADDR_CTRL || a == exc_pkg::ADDR_VBASE) ?
                            exc_pkg::RESP_OKAY : exc_pkg::RESP_SLVERR});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] e;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    for (int n = 0; n < 50 && !rv; n++) begin
      @(negedge aclk);
      ar = arvalid && arready;
      rv = rvalid;
      d = rdata;
      e = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, exp);
    chk({30'h0, e}, {30'h0, er});
  endtask
  // none set: no dispatch may appear in the window
  task automatic fetch(input logic [7:0] v, input logic [31:0] a, input logic none);
    int n;
    n = 0;
    do begin @(negedge aclk); n++; end while (dispatch !== 1'b1 && n < 20);
    if (none) chk({31'h0, dispatch}, 32'h0);
    if (none) return;
    chk({24'h0, dispatch_vec}, {24'h0, v});
    chk(mem_addr, a);
    chk({31'h0, irq_ack}, {31'h0, v == exc_pkg::VEC_NMI || v >= exc_pkg::VEC_EXT_IRQ0});
    n = 0;
    do begin @(negedge aclk); n++; end while (pc_load !== 1'b1 && n < 30);
    chk(pc_value, a ^ KEY);
  endtask
  task automatic take(input exc_pkg::core_req_t t, input logic [7:0] v,
                      input logic [31:0] a, input logic none);
    @(posedge aclk);
    core_req <= t;
    @(posedge aclk);
    r = '0;
    r.boundary = 1'b1;
    r.ctrl_instr = t.ctrl_instr;
    r.rte_done = t.rte_done;
    core_req <= r;
    @(posedge aclk);
    core_req <= '0;
    fetch(v, a, none);
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // run needs well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {aresetn, hw_reset_input, wdt_overflow, awvalid, wvalid, bready, arvalid, rready} = '0;
    {core_req, irq_req, ext, awaddr, araddr, wdata} = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    hw_reset_input <= 1'b1;
    fetch(exc_pkg::VEC_RESET, 32'h0, 1'b0);
    rdchk(exc_pkg::ADDR_CTRL, exc_pkg::CTRL_RESET, exc_pkg::RESP_OKAY);
    rdchk(exc_pkg::ADDR_VBASE, 32'h0, exc_pkg::RESP_OKAY);
    rdchk(8'h40, 32'h0, exc_pkg::RESP_SLVERR);
    wr(exc_pkg::ADDR_STATUS, 32'hff);
    wr(exc_pkg::ADDR_VBASE, VB);
    q = '0;
    q.illegal = 1'b1;
    q.trap = 1'b1;
    q.trap_num = 2'h2;
    take(q, exc_pkg::VEC_ILLEGAL, VB + 32'h10, 1'b0);
    take('0, exc_pkg::VEC_TRAP0 + 8'h2, VB + 32'h28, 1'b0);
    q = '0;
    q.sleep = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(exc_pkg::ADDR_CTRL, (i == 0) ? 32'h60 : (i == 1) ? 32'h68 : 32'h6c);
      take(q, exc_pkg::VEC_SLEEP, VB + 32'h48, i != 1);
    end
    q = '0;
    q.aerr_cpu = 1'b1;
    take(q, exc_pkg::VEC_CPU_AERR, 32'h30, 1'b0);
    q = '0;
    q.aerr_dtc = 1'b1;
    take(q, exc_pkg::VEC_DTC_AERR, VB + 32'h34, 1'b0);
    @(posedge aclk);
    irq_req <= '{nmi: 1'b1, irq: 1'b0, vec: 8'h0};
    take('0, 8'h0, 32'h0, 1'b1);
    wr(exc_pkg::ADDR_CTRL, 32'h10);
    q = '0;
    q.ctrl_instr = 1'b1;
    take(q, 8'h0, 32'h0, 1'b1);
    take('0, exc_pkg::VEC_NMI, VB + 32'h1c, 1'b0);
    @(posedge aclk);
    irq_req <= '0;
    ext <= 12'h008;
    take('0, exc_pkg::VEC_EXT_IRQ0 + 8'h3, VB + 32'h10c, 1'b0);
    @(posedge aclk);
    ext <= '0;
    wdt_overflow <= 1'b1;
    @(posedge aclk);
    wdt_overflow <= 1'b0;
    fetch(exc_pkg::VEC_RESET, 32'h0, 1'b0);
    rdchk(exc_pkg::ADDR_VBASE, 32'h0, exc_pkg::RESP_OKAY);
    wr(exc_pkg::ADDR_CTRL, 32'h3);
    q = '0;
    q.rte_done = 1'b1;
    take(q, 8'h0, 32'h0, 1'b1);
    take('0, exc_pkg::VEC_TRACE, 32'h14, 1'b0);
    @(posedge aclk);
    hw_reset_input <= 1'b0;
    repeat (20) @(posedge aclk);
    #1 chk({31'h0, core_halt}, 32'h1);
    @(posedge aclk);
    hw_reset_input <= 1'b1;
    fetch(exc_pkg::VEC_RESET, 32'h0, 1'b0);
    give_verdict();
  end
endmodule
